/* verilog/charger_regs_pkg.sv */
package charger_regs_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] STATUS_ADDR = 8'h15;
	localparam logic [7:0] CTRL_ADDR   = 8'h16;
	localparam logic [6:0] TARGET_ADDR = 7'h2A;

	// ****************************************
	// Control register fields and reset values
	// ****************************************
	localparam int         PROG_BIT    = 7;
	localparam int         BSW_BIT     = 6;
	localparam int         STBY_BIT    = 5;
	localparam int         WDT_BIT     = 4;
	localparam int         MODE_MSB    = 3;
	localparam logic       PROG_RST    = 1'b0;
	localparam logic       BSW_RST     = 1'b0;
	localparam logic       STBY_RST    = 1'b0;
	localparam logic       WDT_RST     = 1'b0;
	localparam logic [3:0] MODE_RST    = 4'h5;

	// ****************************************
	// Status codes
	// ****************************************
	localparam logic [2:0] ZONE_NORMAL  = 3'h2;
	localparam logic [2:0] ZONE_HOT     = 3'h4;
	localparam logic [2:0] ZONE_REMOVED = 3'h5;
	localparam logic [2:0] ZONE_MON_OFF = 3'h6;
	localparam logic [1:0] FSW_600K     = 2'h0;
	localparam logic [3:0] DETAIL_THERM = 4'hC;
	localparam logic [7:0] STATUS_RST   = 8'h20;

	// ****************************************
	// Power-path modes
	// ****************************************
	localparam logic [3:0] MODE_CONV    = 4'h4;
	localparam logic [3:0] MODE_CHG_LO  = 4'h5;
	localparam logic [3:0] MODE_CHG_HI  = 4'h7;
	localparam logic [3:0] MODE_REVERSE = 4'hA;

	// ****************************************
	// Serial bus
	// ****************************************
	localparam logic [3:0] BYTE_BITS    = 4'h8;

	typedef struct packed {
		logic       scl;
		logic       sda;
		logic [2:0] therm_zone;
		logic       batt_removed;
		logic       therm_mon_off;
		logic       app_charger;
		logic       cell_three;
		logic       switch_pin;
		logic       standby_hold;
		logic [3:0] details;
	} pin_in_t;

	typedef struct packed {
		logic       charger_on;
		logic       converter_on;
		logic       reverse_on;
	} path_t;

	typedef struct packed {
		logic       host_prog;
		logic       use_resistor;
		logic       clr_suspend;
		logic       batt_sw_off;
		logic       standby;
		logic       wdt_en;
		path_t      path;
		logic [3:0] details;
	} ctrl_out_t;

endpackage

/* verilog/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 15
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] d_out
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	assign d_out = sync_ff;

	// ****************************************
	// Two-stage synchroniser per bit
	// ****************************************
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				meta_ff[i] <= 1'b0;
				sync_ff[i] <= 1'b0;
			end else begin
				meta_ff[i] <= d_in[i];
				sync_ff[i] <= meta_ff[i];
			end
		end
	end

endmodule

/* verilog/charger_status_config_regs.sv */
`timescale 1ns/1ps
module charger_status_config_regs (
	// Clock and reset
	input  wire logic       SYS_CLK,
	input  wire logic       RST_N,
	// Serial bus
	input  wire logic       SCL_IN,
	input  wire logic       SDA_IN,
	output logic            SDA_OUT,
	output logic            SDA_OE_N,
	// Live conditions
	input  wire logic [2:0] THERM_ZONE,
	input  wire logic       BATT_REMOVED,
	input  wire logic       THERM_MON_OFF,
	input  wire logic       APP_CHARGER,
	input  wire logic       CELL_THREE,
	input  wire logic       BATT_SWITCH_DISABLE_PIN,
	input  wire logic       STANDBY_HOLD,
	input  wire logic [3:0] CHARGER_STATE_IN,
	// Charger controls
	output logic            HOST_PROG_EN,
	output logic            USE_RESISTOR_SET,
	output logic            CLEAR_RESISTOR_SUSPEND,
	output logic            BATT_SWITCH_OFF,
	output logic            CONVERTER_STANDBY,
	output logic            WATCHDOG_EN,
	output logic            CHARGER_ON,
	output logic            CONVERTER_ON,
	output logic            REVERSE_ON,
	output logic [3:0]      CHARGER_DETAILS
);

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
	} bus_state_t;

	function automatic charger_regs_pkg::path_t mode_decode(input logic [3:0] m);
		charger_regs_pkg::path_t p;
		p = '0;
		if (m == charger_regs_pkg::MODE_CONV) begin
			p.converter_on = 1'b1;
		end else if (m >= charger_regs_pkg::MODE_CHG_LO && m <= charger_regs_pkg::MODE_CHG_HI) begin
			p.converter_on = 1'b1;
			p.charger_on   = 1'b1;
		end else if (m == charger_regs_pkg::MODE_REVERSE) begin
			p.reverse_on = 1'b1;
		end
		return p;
	endfunction

	// ****************************************
	// Input synchronisers
	// ****************************************
	charger_regs_pkg::pin_in_t pins_raw;
	charger_regs_pkg::pin_in_t pins_s;

	assign pins_raw = '{scl: SCL_IN, sda: SDA_IN, therm_zone: THERM_ZONE,
		batt_removed: BATT_REMOVED, therm_mon_off: THERM_MON_OFF,
		app_charger: APP_CHARGER, cell_three: CELL_THREE,
		switch_pin: BATT_SWITCH_DISABLE_PIN, standby_hold: STANDBY_HOLD,
		details: CHARGER_STATE_IN};

	pin_sync #(
		.W     ($bits(charger_regs_pkg::pin_in_t))
	) u_sync (
		.clk   (SYS_CLK),
		.rst_n (RST_N),
		.d_in  (pins_raw),
		.d_out (pins_s)
	);

	// ****************************************
	// Serial target
	// ****************************************
	bus_state_t  state_ff;
	bus_state_t  nxt_state;
	logic [3:0]  cnt_ff;
	logic [3:0]  nxt_cnt;
	logic [7:0]  shift_ff;
	logic [7:0]  nxt_shift;
	logic [7:0]  ptr_ff;
	logic [7:0]  nxt_ptr;
	logic        rw_ff;
	logic        nxt_rw;
	logic        oe_n_ff;
	logic        nxt_oe_n;
	logic        scl_prev_ff;
	logic        sda_prev_ff;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_det;
	logic        stop_det;
	logic        wr_stb;
	logic        do_load;
	logic [7:0]  rd_byte;
	logic [7:0]  status_ff;
	logic [7:0]  ctrl_rd;

	assign scl_rise  = pins_s.scl && !scl_prev_ff;
	assign scl_fall  = !pins_s.scl && scl_prev_ff;
	assign start_det = pins_s.scl && scl_prev_ff && sda_prev_ff && !pins_s.sda;
	assign stop_det  = pins_s.scl && scl_prev_ff && !sda_prev_ff && pins_s.sda;

	always_comb begin
		if (ptr_ff == charger_regs_pkg::STATUS_ADDR) begin
			rd_byte = status_ff;
		end else if (ptr_ff == charger_regs_pkg::CTRL_ADDR) begin
			rd_byte = ctrl_rd;
		end else begin
			rd_byte = 8'h00;
		end
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_shift = shift_ff;
		nxt_ptr   = ptr_ff;
		nxt_rw    = rw_ff;
		nxt_oe_n  = oe_n_ff;
		wr_stb    = 1'b0;
		do_load   = 1'b0;
		if (start_det) begin
			nxt_state = ST_ADDR;
			nxt_cnt   = 4'h0;
			nxt_oe_n  = 1'b1;
		end else if (stop_det) begin
			nxt_state = ST_IDLE;
			nxt_oe_n  = 1'b1;
		end else if (scl_rise) begin
			case (state_ff)
				ST_ADDR, ST_PTR, ST_WDATA: begin
					nxt_shift = {shift_ff[6:0], pins_s.sda};
					nxt_cnt   = cnt_ff + 4'h1;
				end
				ST_RACK: begin
					if (pins_s.sda) begin
						nxt_state = ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state_ff)
				ST_ADDR: begin
					if (cnt_ff == charger_regs_pkg::BYTE_BITS) begin
						if (shift_ff[7:1] == charger_regs_pkg::TARGET_ADDR) begin
							nxt_rw    = shift_ff[0];
							nxt_state = ST_AACK;
							nxt_oe_n  = 1'b0;
						end else begin
							nxt_state = ST_IDLE;
						end
					end
				end
				ST_PTR: begin
					if (cnt_ff == charger_regs_pkg::BYTE_BITS) begin
						nxt_ptr   = shift_ff;
						nxt_state = ST_PACK;
						nxt_oe_n  = 1'b0;
					end
				end
				ST_WDATA: begin
					if (cnt_ff == charger_regs_pkg::BYTE_BITS) begin
						wr_stb    = 1'b1;
						nxt_ptr   = ptr_ff + 8'h01;
						nxt_state = ST_WACK;
						nxt_oe_n  = 1'b0;
					end
				end
				ST_AACK: begin
					if (rw_ff) begin
						do_load = 1'b1;
					end else begin
						nxt_state = ST_PTR;
						nxt_cnt   = 4'h0;
						nxt_oe_n  = 1'b1;
					end
				end
				ST_PACK, ST_WACK: begin
					nxt_state = ST_WDATA;
					nxt_cnt   = 4'h0;
					nxt_oe_n  = 1'b1;
				end
				ST_RDATA: begin
					if (cnt_ff == charger_regs_pkg::BYTE_BITS) begin
						nxt_state = ST_RACK;
						nxt_oe_n  = 1'b1;
					end else begin
						nxt_oe_n  = shift_ff[7];
						nxt_shift = {shift_ff[6:0], 1'b0};
						nxt_cnt   = cnt_ff + 4'h1;
					end
				end
				ST_RACK: begin
					do_load = 1'b1;
				end
				default: begin
				end
			endcase
			if (do_load) begin
				nxt_oe_n  = rd_byte[7];
				nxt_shift = {rd_byte[6:0], 1'b0};
				nxt_cnt   = 4'h1;
				nxt_ptr   = ptr_ff + 8'h01;
				nxt_state = ST_RDATA;
			end
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			state_ff    <= ST_IDLE;
			cnt_ff      <= 4'h0;
			shift_ff    <= 8'h00;
			ptr_ff      <= 8'h00;
			rw_ff       <= 1'b0;
			oe_n_ff     <= 1'b1;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			state_ff    <= nxt_state;
			cnt_ff      <= nxt_cnt;
			shift_ff    <= nxt_shift;
			ptr_ff      <= nxt_ptr;
			rw_ff       <= nxt_rw;
			oe_n_ff     <= nxt_oe_n;
			scl_prev_ff <= pins_s.scl;
			sda_prev_ff <= pins_s.sda;
		end
	end

	// ****************************************
	// Control and status registers
	// ****************************************
	logic       prog_ff;
	logic       nxt_prog;
	logic       bsw_ff;
	logic       nxt_bsw;
	logic       stby_ff;
	logic       nxt_stby;
	logic       wdt_ff;
	logic       nxt_wdt;
	logic [3:0] mode_ff;
	logic [3:0] nxt_mode;
	logic [7:0] nxt_status;
	logic [2:0] zone;
	logic       ctrl_wr;

	assign ctrl_wr = wr_stb && ptr_ff == charger_regs_pkg::CTRL_ADDR;

	always_comb begin
		nxt_prog = prog_ff;
		nxt_bsw  = bsw_ff;
		nxt_stby = stby_ff;
		nxt_wdt  = wdt_ff;
		nxt_mode = mode_ff;
		if (ctrl_wr) begin
			nxt_prog = prog_ff | shift_ff[charger_regs_pkg::PROG_BIT];
			nxt_bsw  = shift_ff[charger_regs_pkg::BSW_BIT];
			nxt_stby = shift_ff[charger_regs_pkg::STBY_BIT];
			nxt_wdt  = shift_ff[charger_regs_pkg::WDT_BIT];
			nxt_mode = shift_ff[charger_regs_pkg::MODE_MSB:0];
		end
		if (pins_s.therm_mon_off) begin
			zone = charger_regs_pkg::ZONE_MON_OFF;
		end else if (pins_s.batt_removed) begin
			zone = charger_regs_pkg::ZONE_REMOVED;
		end else if (pins_s.therm_zone > charger_regs_pkg::ZONE_HOT) begin
			zone = charger_regs_pkg::ZONE_HOT;
		end else begin
			zone = pins_s.therm_zone;
		end
		nxt_status = {1'b0, zone, pins_s.app_charger,
			charger_regs_pkg::FSW_600K, pins_s.cell_three};
	end

	// Switch and standby read back the effective state
	assign ctrl_rd = {prog_ff, bsw_ff | pins_s.switch_pin,
		stby_ff | pins_s.standby_hold, wdt_ff, mode_ff};

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			prog_ff   <= charger_regs_pkg::PROG_RST;
			bsw_ff    <= charger_regs_pkg::BSW_RST;
			stby_ff   <= charger_regs_pkg::STBY_RST;
			wdt_ff    <= charger_regs_pkg::WDT_RST;
			mode_ff   <= charger_regs_pkg::MODE_RST;
			status_ff <= charger_regs_pkg::STATUS_RST;
		end else begin
			prog_ff   <= nxt_prog;
			bsw_ff    <= nxt_bsw;
			stby_ff   <= nxt_stby;
			wdt_ff    <= nxt_wdt;
			mode_ff   <= nxt_mode;
			status_ff <= nxt_status;
		end
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	charger_regs_pkg::ctrl_out_t out_ff;
	charger_regs_pkg::ctrl_out_t nxt_out;
	logic                        therm_cond;

	always_comb begin
		therm_cond = status_ff[6:4] != charger_regs_pkg::ZONE_NORMAL &&
			status_ff[6:4] != charger_regs_pkg::ZONE_MON_OFF;
		nxt_out              = '0;
		nxt_out.host_prog    = prog_ff;
		nxt_out.use_resistor = !prog_ff;
		nxt_out.clr_suspend  = ctrl_wr && shift_ff[charger_regs_pkg::PROG_BIT];
		nxt_out.batt_sw_off  = ctrl_rd[charger_regs_pkg::BSW_BIT];
		nxt_out.standby      = ctrl_rd[charger_regs_pkg::STBY_BIT];
		nxt_out.wdt_en       = wdt_ff;
		if (!ctrl_rd[charger_regs_pkg::STBY_BIT]) begin
			nxt_out.path = mode_decode(mode_ff);
		end
		nxt_out.details = therm_cond ? charger_regs_pkg::DETAIL_THERM : pins_s.details;
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			out_ff  <= '0;
			SDA_OUT <= 1'b0;
		end else begin
			out_ff  <= nxt_out;
			SDA_OUT <= 1'b0;
		end
	end

	assign SDA_OE_N               = oe_n_ff;
	assign HOST_PROG_EN           = out_ff.host_prog;
	assign USE_RESISTOR_SET       = out_ff.use_resistor;
	assign CLEAR_RESISTOR_SUSPEND = out_ff.clr_suspend;
	assign BATT_SWITCH_OFF        = out_ff.batt_sw_off;
	assign CONVERTER_STANDBY      = out_ff.standby;
	assign WATCHDOG_EN            = out_ff.wdt_en;
	assign CHARGER_ON             = out_ff.path.charger_on;
	assign CONVERTER_ON           = out_ff.path.converter_on;
	assign REVERSE_ON             = out_ff.path.reverse_on;
	assign CHARGER_DETAILS        = out_ff.details;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	sequence s_write_one;
		ctrl_wr && shift_ff[7];
	endsequence
	sequence s_addr_hit;
		state_ff == ST_ADDR && scl_fall && !start_det && !stop_det && cnt_ff == 4'h8 &&
			shift_ff[7:1] == charger_regs_pkg::TARGET_ADDR;
	endsequence

	a_prog_sticky: assert property (prog_ff |=> prog_ff)
		else $error("host programming bit cleared");
	a_prog_set: assert property (s_write_one |=> prog_ff && CLEAR_RESISTOR_SUSPEND ##1
		HOST_PROG_EN && !CLEAR_RESISTOR_SUSPEND)
		else $error("write of one not taken");
	a_resistor_mode: assert property (!prog_ff |=> USE_RESISTOR_SET)
		else $error("resistor settings not selected");
	a_zone_code: assert property (status_ff[6:4] != 3'h7 && !status_ff[7])
		else $error("reserved zone or spare bit reported");
	a_zone_off: assert property (pins_s.therm_mon_off |=> status_ff[6:4] == 3'h6)
		else $error("monitor off not reported");
	a_status_bits: assert property (status_ff[3] == $past(pins_s.app_charger) &&
		status_ff[0] == $past(pins_s.cell_three) && status_ff[2:1] == 2'h0)
		else $error("status bits wrong");
	a_therm_detail: assert property (status_ff[6:4] == 3'h0 |=> CHARGER_DETAILS == 4'hC)
		else $error("thermistor detail code missing");
	a_switch_off: assert property (pins_s.switch_pin |=> BATT_SWITCH_OFF)
		else $error("pin did not force switch off");
	a_standby_path: assert property ((stby_ff || pins_s.standby_hold) |=>
		CONVERTER_STANDBY && !CONVERTER_ON)
		else $error("standby did not stop converter");
	a_mode_reverse: assert property (mode_ff == 4'hA && !stby_ff && !pins_s.standby_hold |=>
		REVERSE_ON && !CHARGER_ON)
		else $error("reverse mode not decoded");
	a_addr_ack: assert property (s_addr_hit |=> !SDA_OE_N)
		else $error("address not acknowledged");

endmodule

/* bench/host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model (
	// Clock
	input  wire logic clk,
	// Serial bus
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_drv
);
	initial begin
		scl     = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask

	// ****************************************
	// Bus conditions and bits
	// ****************************************
	task automatic start_cond();
		wt(3);
		sda_drv = 1'b1;
		wt(4);
		scl = 1'b1;
		wt(8);
		sda_drv = 1'b0;
		wt(8);
		scl = 1'b0;
	endtask

	task automatic stop_cond();
		wt(3);
		sda_drv = 1'b0;
		wt(4);
		scl = 1'b1;
		wt(8);
		sda_drv = 1'b1;
		wt(8);
	endtask

	task automatic bit_out(input logic v);
		wt(3);
		sda_drv = v;
		wt(4);
		scl = 1'b1;
		wt(8);
		scl = 1'b0;
	endtask

	task automatic bit_in(output logic v);
		wt(3);
		sda_drv = 1'b1;
		wt(4);
		scl = 1'b1;
		wt(4);
		v = sda_line;
		wt(4);
		scl = 1'b0;
	endtask

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic v;
		for (int i = 7; i >= 0; i--) begin
			bit_out(b[i]);
		end
		bit_in(v);
		ack = ~v;
	endtask

	// ****************************************
	// Single-byte register transfers
	// ****************************************
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [7:0] data, output logic ok);
		logic a0, a1, a2;
		start_cond();
		send_byte({dev, 1'b0}, a0);
		send_byte(ptr, a1);
		send_byte(data, a2);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask

	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
		output logic [7:0] data, output logic ok);
		logic a0, a1, a2;
		start_cond();
		send_byte({dev, 1'b0}, a0);
		send_byte(ptr, a1);
		start_cond();
		send_byte({dev, 1'b1}, a2);
		for (int i = 7; i >= 0; i--) begin
			bit_in(data[i]);
		end
		bit_out(1'b1);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask
endmodule

/* bench/charger_status_config_regs_tb.sv */
`timescale 1ns/1ps
module charger_status_config_regs_tb;
	typedef struct packed {
		logic [2:0] zone;
		logic [3:0] flags;
		logic [7:0] status;
		logic [3:0] details;
	} row_t;

	logic       sys_clk  = 1'b0;
	logic       rst_n    = 1'b0;
	logic       scl, sda_drv, sda_out, sda_oe_n, sda_line, ok;
	logic [2:0] zone     = 3'h0;
	logic [3:0] flags    = 4'h0;
	logic       sw_pin   = 1'b0;
	logic       hold     = 1'b0;
	logic [3:0] state_in = 4'h3;
	logic       prog, use_res, clr_susp, bsw_off, standby, wdt, chg_on, conv_on, rev_on;
	logic [3:0] details;
	logic [7:0] rd;
	int         failures = 0, check_count = 0, cycles = 0, pulses = 0, p0;
	logic [3:0] modes [4] = '{4'h4, 4'h5, 4'hA, 4'h0};
	logic [2:0] paths [4] = '{3'h2, 3'h6, 3'h1, 3'h0};
	row_t       rows [9]  = '{
		'{3'h0, 4'h0, 8'h00, 4'hC}, '{3'h1, 4'h2, 8'h18, 4'hC},
		'{3'h2, 4'h3, 8'h29, 4'h3}, '{3'h3, 4'h1, 8'h31, 4'hC},
		'{3'h4, 4'h0, 8'h40, 4'hC}, '{3'h7, 4'h0, 8'h40, 4'hC},
		'{3'h2, 4'h8, 8'h50, 4'hC}, '{3'h0, 4'hE, 8'h68, 4'h3},
		'{3'h2, 4'h3, 8'h29, 4'h3}};

	// Open-drain line with pull-up
	assign sda_line = sda_drv & (sda_oe_n | sda_out);

	charger_status_config_regs charger_status_config_regs_i (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda_line),
		.SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .THERM_ZONE(zone),
		.BATT_REMOVED(flags[3]), .THERM_MON_OFF(flags[2]), .APP_CHARGER(flags[1]),
		.CELL_THREE(flags[0]), .BATT_SWITCH_DISABLE_PIN(sw_pin), .STANDBY_HOLD(hold),
		.CHARGER_STATE_IN(state_in), .HOST_PROG_EN(prog), .USE_RESISTOR_SET(use_res),
		.CLEAR_RESISTOR_SUSPEND(clr_susp), .BATT_SWITCH_OFF(bsw_off),
		.CONVERTER_STANDBY(standby), .WATCHDOG_EN(wdt), .CHARGER_ON(chg_on),
		.CONVERTER_ON(conv_on), .REVERSE_ON(rev_on), .CHARGER_DETAILS(details));

	host_bus_model host_bus_model_i (
		.clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

	always #10 sys_clk = ~sys_clk;

	// Pulse counter and hang guard
	always @(negedge sys_clk) begin
		cycles++;
		if (clr_susp === 1'b1) pulses++;
		if (cycles == 60000) begin
			failures++;
			tally_and_finish();
		end
	end

	// ****************************************
	// Checks and bus helpers
	// ****************************************
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_out(input logic [3:0] got, input logic [3:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
		host_bus_model_i.write_reg(charger_regs_pkg::TARGET_ADDR, ptr, data, ok);
		chk_out({3'h0, ok}, 4'h1, "write ack");
	endtask

	task automatic rdchk(input logic [7:0] ptr, input logic [7:0] exp, input string what);
		host_bus_model_i.read_reg(charger_regs_pkg::TARGET_ADDR, ptr, rd, ok);
		chk_byte(rd, exp, what);
	endtask

	task automatic done(input string name);
		$display("test %s done, %0d checks so far", name, check_count);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (6) @(negedge sys_clk);
		foreach (rows[i]) begin
			zone  = rows[i].zone;
			flags = rows[i].flags;
			repeat (8) @(negedge sys_clk);
			chk_out(details, rows[i].details, "details");
			rdchk(charger_regs_pkg::STATUS_ADDR, rows[i].status, "status");
		end
		done("status table");
		chk_out({prog, use_res, wdt, bsw_off}, 4'h4, "reset controls");
		chk_out({1'b0, chg_on, conv_on, rev_on}, 4'h6, "reset path");
		rdchk(charger_regs_pkg::CTRL_ADDR, 8'h05, "control reset");
		done("reset values");
		foreach (modes[i]) begin
			wr(charger_regs_pkg::CTRL_ADDR, {4'h0, modes[i]});
			chk_out({1'b0, chg_on, conv_on, rev_on}, {1'b0, paths[i]}, "mode path");
			rdchk(charger_regs_pkg::CTRL_ADDR, {4'h0, modes[i]}, "mode readback");
		end
		done("modes");
		wr(charger_regs_pkg::CTRL_ADDR, 8'h75);
		chk_out({bsw_off, standby, wdt, chg_on | conv_on | rev_on}, 4'hE, "forced bits");
		rdchk(charger_regs_pkg::CTRL_ADDR, 8'h75, "forced readback");
		wr(charger_regs_pkg::CTRL_ADDR, 8'h05);
		sw_pin = 1'b1;
		hold   = 1'b1;
		repeat (8) @(negedge sys_clk);
		chk_out({bsw_off, standby, wdt, chg_on}, 4'hC, "effective outputs");
		rdchk(charger_regs_pkg::CTRL_ADDR, 8'h65, "effective readback");
		sw_pin = 1'b0;
		hold   = 1'b0;
		repeat (8) @(negedge sys_clk);
		rdchk(charger_regs_pkg::CTRL_ADDR, 8'h05, "released readback");
		done("control bits");
		p0 = pulses;
		wr(charger_regs_pkg::CTRL_ADDR, 8'h85);
		chk_out({prog, use_res, 2'h0}, 4'h8, "programming set");
		chk_out(4'(pulses - p0), 4'h1, "suspend clear pulse");
		wr(charger_regs_pkg::CTRL_ADDR, 8'h05);
		rdchk(charger_regs_pkg::CTRL_ADDR, 8'h85, "sticky programming");
		chk_out(4'(pulses - p0), 4'h1, "no pulse on zero");
		done("programming enable");
		wr(charger_regs_pkg::STATUS_ADDR, 8'hFF);
		rdchk(charger_regs_pkg::STATUS_ADDR, rows[8].status, "status read only");
		rdchk(8'h30, 8'h00, "unmapped read");
		host_bus_model_i.write_reg(charger_regs_pkg::TARGET_ADDR ^ 7'h01, 8'h16, 8'h00, ok);
		chk_out({3'h0, ok}, 4'h0, "foreign address");
		rdchk(charger_regs_pkg::CTRL_ADDR, 8'h85, "after foreign write");
		done("refusals");
		rst_n = 1'b0;
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		repeat (6) @(negedge sys_clk);
		chk_out({prog, use_res, wdt, bsw_off}, 4'h4, "second reset");
		rdchk(charger_regs_pkg::CTRL_ADDR, 8'h05, "control after reset");
		done("second reset");
		tally_and_finish();
	end
endmodule
